/* File: common/mem_event_pkg.sv */
/*
 file holds: constants, register offsets and carrier types of the
 memory array event and interrupt block.
 assumes: one clock aclk, AXI4-Lite register access, 32-bit data.
*/
package mem_event_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_SIGNAL_EN = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_STATUS_EN = 8'h08;
  localparam logic [7:0] OFF_SYS_TRAP = 8'h0C;
  localparam logic [7:0] OFF_DATA_TRAP = 8'h10;
  localparam logic [7:0] OFF_INSTR_TRAP = 8'h14;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;
  localparam logic [7:0] OFF_INT_PEND = 8'h1C;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // trap register fields: address in [15:0], direction select in bit 16
  localparam int TRAP_ADDR_LSB = 0;
  localparam int TRAP_ADDR_W = 16;
  localparam int TRAP_DIR_BIT = 16;
  // event kinds, five bits per memory in every event register
  localparam int EV_RANGE = 0;
  localparam int EV_TRAP = 1;
  localparam int EV_SINGLE = 2;
  localparam int EV_MULTI = 3;
  localparam int EV_PARTIAL = 4;
  localparam int EV_KINDS = 5;
  // memories: 0 system bus, 1 data even, 2 data odd, 3 instruction
  localparam int MEM_SYS = 0;
  localparam int MEM_DEVEN = 1;
  localparam int MEM_DODD = 2;
  localparam int MEM_INSTR = 3;
  localparam int MEMS = 4;
  localparam int EV_BITS = EV_KINDS * MEMS;

  // one access seen on a memory port, valid for a single cycle
  typedef struct packed {
    logic valid;
    logic write;
    logic partial;
    logic [31:0] addr;
    logic single_err;
    logic multi_err;
  } mem_access_t;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] size;
  } mem_window_t;
endpackage

/* File: rtl/mem_access_watch.sv */
/*
 file holds: event detector for one memory port.
 assumes: access strobes come from logic on aclk, one cycle each.
*/
module mem_access_watch
  import mem_event_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire mem_event_pkg::mem_access_t acc,
  input wire mem_event_pkg::mem_window_t win,
  input wire logic [31:0] trap_reg,
  input wire logic ecc_on,
  output logic [4:0] events_q
);
  logic [31:0] offs;
  logic in_range;
  logic trap_hit;

  // offset within the memory window and range test
  assign offs = acc.addr - win.base;
  assign in_range = (acc.addr >= win.base) && (offs < win.size);
  // trap compares 16-bit offset; select 0 reads, 1 writes
  assign trap_hit = in_range &&
    (offs[TRAP_ADDR_W-1:0] ==
     trap_reg[TRAP_ADDR_LSB +: TRAP_ADDR_W]) &&
    (acc.write == trap_reg[TRAP_DIR_BIT]);

  // registered one-cycle event pulses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      events_q <= '0;
    else
    begin
      events_q[EV_RANGE] <= acc.valid && !in_range;
      events_q[EV_TRAP] <= acc.valid && trap_hit;
      events_q[EV_SINGLE] <= acc.valid && !acc.write &&
        acc.single_err && !acc.multi_err;
      events_q[EV_MULTI] <= acc.valid && !acc.write &&
        acc.multi_err;
      events_q[EV_PARTIAL] <= acc.valid && acc.write &&
        acc.partial && ecc_on;
    end
  end
endmodule

/* File: rtl/axil_regs.sv */
/*
 file holds: AXI4-Lite slave front end, one read and one write at once.
 assumes: aligned 32-bit accesses; the core answers reads the same cycle.
*/
module axil_regs
  import mem_event_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err,
  input wire logic wr_err
);
  logic aw_have_q, w_have_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;

  assign s_awready = !aw_have_q && !s_bvalid;
  assign s_wready = !w_have_q && !s_bvalid;
  assign wr_en = aw_have_q && w_have_q && !s_bvalid;
  assign wr_addr = aw_q;
  assign wr_data = w_q;
  assign wr_strb = s_q;
  assign s_arready = !s_rvalid;
  assign rd_en = s_arvalid && !s_rvalid;
  assign rd_addr = s_araddr;

  // write address and data taken in either order, response after both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      s_q <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_have_q <= 1'b1;
        aw_q <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_have_q <= 1'b1;
        w_q <= s_wdata;
        s_q <= s_wstrb;
      end
      if (wr_en)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_err ? 2'h2 : 2'h0;
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // read data registered one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'h0;
    end
    else if (rd_en)
    begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_data;
      s_rresp <= rd_err ? 2'h2 : 2'h0;
    end
    else if (s_rvalid && s_rready)
      s_rvalid <= 1'b0;
  end
endmodule

/* File: rtl/memory_array_event_irq.sv */
/*
 file holds: event and interrupt logic of the configurable memory array.
 assumes: access strobes on aclk; memory windows are set by the array
 configuration logic; registers reached over AXI4-Lite.
*/
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
// What this block does
// - an access outside its memory window is an out-of-range event.
// - a partial write is an event only while ecc is enabled.
// - read ecc faults are single-bit or multi-bit events, apart.
// - each memory and kind has a signal enable gating event_irq_q.
// - all enabled events are ORed into one interrupt request.
// - one status bit per kind for each of the four memories.
// - writing one clears a status bit, zero leaves it.
// - a status bit is set only while its status enable is set.
// - each memory has a trap register of address and direction; both data halves share one.
// - the trap address is a 16-bit offset in its memory window.
// - direction 0 traps reads, 1 traps writes.
// - a trap hit with the chosen direction raises its event.
module memory_array_event_irq
  import mem_event_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire mem_event_pkg::mem_access_t sys_acc,
  input wire mem_event_pkg::mem_access_t deven_acc,
  input wire mem_event_pkg::mem_access_t dodd_acc,
  input wire mem_event_pkg::mem_access_t instr_acc,
  input wire mem_event_pkg::mem_window_t sys_win,
  input wire mem_event_pkg::mem_window_t data_win,
  input wire mem_event_pkg::mem_window_t instr_win,
  input wire logic [MEMS-1:0] ecc_enable,
  output logic event_irq_q,
  output logic mem_irq_q
);
  import mem_event_pkg::*;

  logic [31:0] irq_signal_enable_q;
  logic [31:0] irq_status_flags_q;
  logic [31:0] irq_status_enable_q;
  logic [31:0] sysbus_mem_trap_address_q;
  logic [31:0] data_mem_trap_address_q;
  logic [31:0] instr_mem_trap_address_q;
  logic [31:0] int_mask_q;
  logic [31:0] int_pend_q;
  logic wr_en, rd_en;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_data;
  logic rd_err, wr_err;
  logic [EV_BITS-1:0] ev;
  logic [31:0] ev_word;
  logic [31:0] pend_set;

  ////////////////////////////////////////////////////////////////////////
  // bus front end

  axil_regs u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err),
    .wr_err(wr_err)
  );

  ////////////////////////////////////////////////////////////////////////
  // per-memory event detectors; the data halves share one trap register

  mem_access_watch u_sys (
    .aclk(aclk),
    .aresetn(aresetn),
    .acc(sys_acc),
    .win(sys_win),
    .trap_reg(sysbus_mem_trap_address_q),
    .ecc_on(ecc_enable[MEM_SYS]),
    .events_q(ev[MEM_SYS*EV_KINDS +: EV_KINDS])
  );

  mem_access_watch u_deven (
    .aclk(aclk),
    .aresetn(aresetn),
    .acc(deven_acc),
    .win(data_win),
    .trap_reg(data_mem_trap_address_q),
    .ecc_on(ecc_enable[MEM_DEVEN]),
    .events_q(ev[MEM_DEVEN*EV_KINDS +: EV_KINDS])
  );

  mem_access_watch u_dodd (
    .aclk(aclk),
    .aresetn(aresetn),
    .acc(dodd_acc),
    .win(data_win),
    .trap_reg(data_mem_trap_address_q),
    .ecc_on(ecc_enable[MEM_DODD]),
    .events_q(ev[MEM_DODD*EV_KINDS +: EV_KINDS])
  );

  mem_access_watch u_instr (
    .aclk(aclk),
    .aresetn(aresetn),
    .acc(instr_acc),
    .win(instr_win),
    .trap_reg(instr_mem_trap_address_q),
    .ecc_on(ecc_enable[MEM_INSTR]),
    .events_q(ev[MEM_INSTR*EV_KINDS +: EV_KINDS])
  );

  assign ev_word = {{(32-EV_BITS){1'b0}}, ev};

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // expand byte strobes to a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic hit(input logic en, input logic [7:0] a,
                               input logic [7:0] off);
    return en && (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // read decode and unmapped answers

  always_comb
  begin
    rd_err = 1'b0;
    case (rd_addr)
      OFF_SIGNAL_EN: rd_data = irq_signal_enable_q;
      OFF_STATUS: rd_data = irq_status_flags_q;
      OFF_STATUS_EN: rd_data = irq_status_enable_q;
      OFF_SYS_TRAP: rd_data = sysbus_mem_trap_address_q;
      OFF_DATA_TRAP: rd_data = data_mem_trap_address_q;
      OFF_INSTR_TRAP: rd_data = instr_mem_trap_address_q;
      OFF_INT_MASK: rd_data = int_mask_q;
      OFF_INT_PEND: rd_data = int_pend_q;
      default:
      begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  always_comb
  begin
    case (wr_addr)
      OFF_SIGNAL_EN, OFF_STATUS, OFF_STATUS_EN, OFF_SYS_TRAP,
      OFF_DATA_TRAP, OFF_INSTR_TRAP, OFF_INT_MASK, OFF_INT_PEND:
        wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // software-written configuration registers

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_signal_enable_q <= RST_ZERO;
      irq_status_enable_q <= RST_ZERO;
      sysbus_mem_trap_address_q <= RST_ZERO;
      data_mem_trap_address_q <= RST_ZERO;
      instr_mem_trap_address_q <= RST_ZERO;
      int_mask_q <= RST_ZERO;
    end
    else
    begin
      // gate writes by implemented bits
      if (hit(wr_en, wr_addr, OFF_SIGNAL_EN))
        irq_signal_enable_q <= merge(irq_signal_enable_q, wr_data,
                                     wr_strb) & ev_mask();
      if (hit(wr_en, wr_addr, OFF_STATUS_EN))
        irq_status_enable_q <= merge(irq_status_enable_q, wr_data,
                                     wr_strb) & ev_mask();
      if (hit(wr_en, wr_addr, OFF_SYS_TRAP))
        sysbus_mem_trap_address_q <= merge(sysbus_mem_trap_address_q,
          wr_data, wr_strb) & trap_mask();
      if (hit(wr_en, wr_addr, OFF_DATA_TRAP))
        data_mem_trap_address_q <= merge(data_mem_trap_address_q,
          wr_data, wr_strb) & trap_mask();
      if (hit(wr_en, wr_addr, OFF_INSTR_TRAP))
        instr_mem_trap_address_q <= merge(instr_mem_trap_address_q,
          wr_data, wr_strb) & trap_mask();
      if (hit(wr_en, wr_addr, OFF_INT_MASK))
        int_mask_q <= merge(int_mask_q, wr_data, wr_strb) & ev_mask();
    end
  end

  function automatic logic [31:0] ev_mask();
    return {{(32-EV_BITS){1'b0}}, {EV_BITS{1'b1}}};
  endfunction

  function automatic logic [31:0] trap_mask();
    return 32'h0001_FFFF;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // status flags: set behind status enable, write one to clear, set wins

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status_flags_q <= RST_ZERO;
    else
      irq_status_flags_q <= (irq_status_flags_q &
        ~(hit(wr_en, wr_addr, OFF_STATUS) ?
          (wr_data & lanes(wr_strb)) : 32'h0000_0000))
        | (ev_word & irq_status_enable_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // pending copy for the local interrupt, cleared by reading it

  assign pend_set = ev_word & irq_status_enable_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_pend_q <= RST_ZERO;
    else if (hit(rd_en, rd_addr, OFF_INT_PEND))
      int_pend_q <= pend_set;
    else
      int_pend_q <= int_pend_q | pend_set;
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt outputs

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      event_irq_q <= 1'b0;
      mem_irq_q <= 1'b0;
    end
    else
    begin
      event_irq_q <= |(irq_status_flags_q & irq_signal_enable_q);
      mem_irq_q <= |(int_pend_q & int_mask_q);
    end
  end
endmodule

/* File: testbench/mem_irq_checker_assertions.sv */
/*
 holds: port checks of the memory event interrupt block.
 assumes: bound from the bench top, one clock aclk, sync reset low.
*/
module mem_irq_checker
  import mem_event_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire mem_event_pkg::mem_access_t sys_acc,
  input wire mem_event_pkg::mem_access_t deven_acc,
  input wire mem_event_pkg::mem_access_t dodd_acc,
  input wire mem_event_pkg::mem_access_t instr_acc,
  input wire logic event_irq_q,
  input wire logic mem_irq_q
);
  logic any_acc;
  logic [3:0] acc_gap_q;
  logic [3:0] wr_gap_q;
  logic [3:0] bus_gap_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  // a strobe on any memory port
  assign any_acc = sys_acc.valid | deven_acc.valid | dodd_acc.valid
    | instr_acc.valid;
  // cycles since the last strobe, write, or any bus request; saturating
  always_ff @(posedge aclk)
  begin
    acc_gap_q <= !aresetn ? 4'hF : any_acc ? 4'h0
      : acc_gap_q + {3'h0, acc_gap_q != 4'hF};
    wr_gap_q <= !aresetn ? 4'hF : (s_awvalid && s_awready) ? 4'h0
      : wr_gap_q + {3'h0, wr_gap_q != 4'hF};
    bus_gap_q <= !aresetn ? 4'hF
      : ((s_awvalid && s_awready) || (s_arvalid && s_arready)) ? 4'h0
      : bus_gap_q + {3'h0, bus_gap_q != 4'hF};
  end
  //////////////////////////////////////////////////////////////////////////
  bresp_hold_a: assert property (
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped early");
  ar_block_a: assert property (s_rvalid |-> !s_arready)
    else $error("read accepted during answer");
  rd_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (
    s_awvalid && s_awready && s_wvalid && s_wready |=> ##1 s_bvalid)
    else $error("write answer late");
  irq_cause_a: assert property (
    $rose(event_irq_q) |-> acc_gap_q <= 4'h5 || wr_gap_q <= 4'h5)
    else $error("interrupt rose without cause");
  irq_hold_a: assert property ($fell(event_irq_q) |-> wr_gap_q <= 4'h5)
    else $error("interrupt fell without clear");
  pend_hold_a: assert property ($fell(mem_irq_q) |-> bus_gap_q <= 4'h6)
    else $error("pending interrupt fell alone");
  pend_cause_a: assert property (
    $rose(mem_irq_q) |-> acc_gap_q <= 4'h5 || bus_gap_q <= 4'h6)
    else $error("pending interrupt rose without cause");
  cover property ($rose(event_irq_q));
  cover property ($fell(mem_irq_q));
  cover property (s_rvalid && s_rresp == 2'h2);
endmodule

/* File: testbench/mem_port_model.sv */
/*
 holds: model of the memory access ports that feed the event block.
 assumes: the bench calls fire from one process, one access at a time.
*/
module mem_port_model
  import mem_event_pkg::*;
(
  input wire logic aclk,
  output mem_event_pkg::mem_access_t sys_acc,
  output mem_event_pkg::mem_access_t deven_acc,
  output mem_event_pkg::mem_access_t dodd_acc,
  output mem_event_pkg::mem_access_t instr_acc
);
  timeunit 1ns;
  timeprecision 1ps;
  mem_access_t drv [4] = '{default: '0};
  //////////////////////////////////////////////////////////////////////////
  // each port shows its own slot
  assign sys_acc = drv[0];
  assign deven_acc = drv[1];
  assign dodd_acc = drv[2];
  assign instr_acc = drv[3];
  // one-cycle strobe; the idle payload is inverted so stale use shows
  task automatic fire(input int p, input mem_access_t a);
    @(posedge aclk);
    drv[p] <= a;
    @(posedge aclk);
    drv[p] <= {1'b0, ~a[$bits(mem_access_t)-2:0]};
  endtask
endmodule

/* File: testbench/testbench.sv */
/*
 holds: self-checking bench of the memory event interrupt block.
 assumes: package mem_event_pkg, the checker and the port model.
*/
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("[ERR] %0t %s", $time, m); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mem_event_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic event_irq_q, mem_irq_q;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata, r, bitv;
  mem_access_t sys_acc, deven_acc, dodd_acc, instr_acc;
  mem_window_t sys_win = '{32'h2020_0000, 32'h0001_0000};
  mem_window_t data_win = '{32'h2000_0000, 32'h0001_0000};
  mem_window_t instr_win = '{32'h0000_0000, 32'h0001_0000};
  logic [31:0] base_of [4] = '{32'h2020_0000, 32'h2000_0000,
    32'h2000_0000, 32'h0};
  logic [7:0] toff [4] = '{OFF_SYS_TRAP, OFF_DATA_TRAP, OFF_DATA_TRAP,
    OFF_INSTR_TRAP};
  logic [3:0] ecc_enable = 4'hF;
  logic [31:0] seed = 32'h0001_4B09;
  logic [33:0] exp_q [$];
  int n_errors = 0;
  int checks_done = 0;
  //////////////////////////////////////////////////////////////////////////
  memory_array_event_irq dut (.aclk, .aresetn, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .sys_acc, .deven_acc, .dodd_acc,
    .instr_acc, .sys_win, .data_win, .instr_win, .ecc_enable,
    .event_irq_q, .mem_irq_q);
  mem_port_model pm (.aclk, .sys_acc, .deven_acc, .dodd_acc, .instr_acc);
  // free-running clock
  always #5 aclk = ~aclk;
  // read answers against the oldest note, seen the cycle they are taken
  always @(negedge aclk)
  begin
    if (s_rvalid && s_rready)
      `CHK({s_rresp, s_rdata}, exp_q.pop_front(), "read data")
  end
  //////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // bus write: address and data offered together, each dropped when taken
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    rb = 1'b0;
    while (!rb)
    begin
      @(negedge aclk);
      ra = s_awready;
      rw = s_wready;
      rb = s_bvalid;
      @(posedge aclk);
      if (ra) s_awvalid <= 1'b0;
      if (rw) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b0;
  endtask
  // bus read: the expected response and data are noted first
  task axr(input logic [7:0] a, input logic [33:0] e);
    logic ra, rv;
    exp_q.push_back(e);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    rv = 1'b0;
    while (!rv)
    begin
      @(negedge aclk);
      ra = s_arready;
      rv = s_rvalid;
      @(posedge aclk);
      if (ra) s_arvalid <= 1'b0;
    end
    s_rready <= 1'b0;
  endtask
  task hit(input int m, input mem_access_t a);
    pm.fire(m, a);
    repeat (4) @(posedge aclk);
  endtask
  // one access that causes event kind k on memory m
  task ev(input int m, input int k);
    logic [31:0] a;
    a = base_of[m] + (k == 0 ? 32'h0001_0000 : k == 1 ? 32'h40
      : 32'h100 + (xs() & 32'h7F00));
    hit(m, {1'b1, k == 4, k == 4, a, k == 2, k == 3});
  endtask
  task results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the expected run
  initial
  begin
    #100us;
    n_errors++;
    $display("[ERR] %0t timeout", $time);
    results();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) axr(8'(i * 4), 34'h0);
    axr(8'h20, {2'h2, 32'h0});
    r = xs() & 32'h000F_FFFF;
    axw(OFF_SIGNAL_EN, r);
    axr(OFF_SIGNAL_EN, {2'h0, r});
    $display("test registers done");
    axw(OFF_SIGNAL_EN, 32'h000F_FFFF);
    axw(OFF_STATUS_EN, 32'h000F_FFFF);
    for (int m = 0; m < 4; m++) axw(toff[m], 32'h0000_0040);
    axw(OFF_INT_MASK, 32'h1);
    ev(0, 0);
    `CHK(mem_irq_q, 1'b1, "pending irq")
    axr(OFF_INT_PEND, {2'h0, 32'h1});
    axr(OFF_INT_PEND, 34'h0);
    `CHK(mem_irq_q, 1'b0, "pending irq held")
    axw(OFF_STATUS, 32'h1);
    $display("test pending done");
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 5; k++)
      begin
        bitv = 32'h1 << (m * 5 + k);
        ev(m, k);
        `CHK(event_irq_q, 1'b1, "event irq")
        axr(OFF_STATUS, {2'h0, bitv});
        axw(OFF_STATUS, 32'h0);
        axr(OFF_STATUS, {2'h0, bitv});
        axw(OFF_STATUS, bitv);
        axr(OFF_STATUS, 34'h0);
        `CHK(event_irq_q, 1'b0, "irq after clear")
      end
    $display("test events done");
    axw(OFF_STATUS_EN, 32'h0);
    ev(0, 0);
    axr(OFF_STATUS, 34'h0);
    axw(OFF_STATUS_EN, 32'h000F_FFFF);
    axw(OFF_SIGNAL_EN, 32'h0);
    ev(3, 0);
    `CHK(event_irq_q, 1'b0, "masked event irq")
    axr(OFF_STATUS, {2'h0, 32'h1 << 15});
    axw(OFF_STATUS, 32'h000F_FFFF);
    ecc_enable <= 4'h0;
    ev(1, 4);
    axr(OFF_STATUS, 34'h0);
    hit(2, {1'b1, 1'b1, 1'b0, 32'h2000_0040, 1'b0, 1'b0});
    axr(OFF_STATUS, 34'h0);
    axw(OFF_DATA_TRAP, 32'h0001_0040);
    hit(2, {1'b1, 1'b1, 1'b0, 32'h2000_0040, 1'b0, 1'b0});
    axr(OFF_STATUS, {2'h0, 32'h1 << 11});
    $display("test gates done");
    results();
  end
endmodule
bind memory_array_event_irq mem_irq_checker chk (.aclk, .aresetn,
  .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
  .s_bready, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
  .s_rready, .sys_acc, .deven_acc, .dodd_acc, .instr_acc, .event_irq_q,
  .mem_irq_q);
